// ===== design/dcs_params.svh
// Constants of the DDR command sequencer: encodings, field positions, reset values and sizes.
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH
`define DCS_AW 12
`define DCS_CW 8
`define DCS_BW 2
`define DCS_NBANK 4
`define DCS_DW 32
`define DCS_MW 4
`define DCS_A10 10
`define DCS_FIFO_DEPTH 8
`define DCS_CMD_MRS 3'h0
`define DCS_CMD_REF 3'h1
`define DCS_CMD_PRE 3'h2
`define DCS_CMD_ACT 3'h3
`define DCS_CMD_WR 3'h4
`define DCS_CMD_RD 3'h5
`define DCS_CMD_BST 3'h6
`define DCS_CMD_NOP 3'h7
`define DCS_BL_2 3'h1
`define DCS_BL_4 3'h2
`define DCS_BL_8 3'h3
`define DCS_MR_BL_MSB 2
`define DCS_MR_BT_BIT 3
`define DCS_MR_CL_MSB 6
`define DCS_MR_CL_LSB 4
`define DCS_MR_BL_RST 3'h1
`define DCS_MR_CL_RST 3'h2
`endif

// ===== design/dcs_pkg.sv
// Types shared by the DDR command sequencer and its write buffer.
`include "dcs_params.svh"
package dcs_pkg;
   typedef struct packed {
      logic                 cke;
      logic                 cs_n;
      logic                 ras_n;
      logic                 cas_n;
      logic                 we_n;
      logic [`DCS_BW-1:0]   ba;
      logic [`DCS_AW-1:0]   addr;
      logic                 wvld;
      logic [`DCS_DW-1:0]   wdata;
      logic [`DCS_MW-1:0]   wmask;
   } dcs_pin_t;
   typedef struct packed {
      logic                 vld;
      logic [`DCS_BW-1:0]   bank;
      logic [`DCS_CW-1:0]   col0;
      logic [`DCS_CW-1:0]   col1;
   } dcs_rd_t;
   typedef struct packed {
      logic [`DCS_BW-1:0]   bank;
      logic [`DCS_CW-1:0]   col0;
      logic [`DCS_CW-1:0]   col1;
      logic [`DCS_DW-1:0]   data;
      logic [`DCS_MW-1:0]   mask;
   } dcs_wr_t;
   typedef enum logic [2:0] {
      DCS_IDLE  = 3'h1,
      DCS_READ  = 3'h2,
      DCS_WRITE = 3'h4
   } dcs_st_t;
   typedef enum logic [2:0] {
      DCS_PD_NONE = 3'h1,
      DCS_PD_PRE  = 3'h2,
      DCS_PD_ACT  = 3'h4
   } dcs_pd_t;
endpackage : dcs_pkg

// ===== design/dcs_seq.sv
// DDR command sequencer with its write data buffer.
`timescale 1ns/10ps
`default_nettype none
`include "dcs_params.svh"

module dcs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `DCS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Filling side
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   // Draining side
   output logic                  out_valid_out,
   output logic [WIDTH-1:0]      out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wp_ff, rp_ff, nxt_wp, nxt_rp;
   logic [AW:0]      cnt_ff, nxt_cnt;
   logic             rdy_ff, vld_ff, nxt_rdy, nxt_vld, push, pop;

   always_comb begin
      push    = in_valid_in && rdy_ff;
      pop     = vld_ff && out_ready_in;
      nxt_wp  = wp_ff + AW'(push);
      nxt_rp  = rp_ff + AW'(pop);
      nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      nxt_rdy = nxt_cnt != (AW+1)'(DEPTH);
      nxt_vld = nxt_cnt != '0;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
         rdy_ff <= 1'b1;
         vld_ff <= 1'b0;
      end else begin
         wp_ff  <= nxt_wp;
         rp_ff  <= nxt_rp;
         cnt_ff <= nxt_cnt;
         rdy_ff <= nxt_rdy;
         vld_ff <= nxt_vld;
      end
   end

   // The array has no reset; only the pointers and the count say what is valid.
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_ff[wp_ff] <= in_data_in;
      end
   end

   assign in_ready_out  = rdy_ff;
   assign out_valid_out = vld_ff;
   assign out_data_out  = mem_ff[rp_ff];
endmodule : dcs_fifo

// What this block does
// - A10 with read or write selects self-timed precharge of that row after the burst.
// - Precharge closes the addressed bank with A10 low, all banks with A10 high.
// - Power-down is precharge type with all banks idle, active type otherwise.
// - A new read to an open row interrupts an ongoing read burst of 4 or 8.
// - A new write truncates an ongoing write burst and takes the new data.
// - Burst-terminate stops an ongoing read burst early after the scheduled elements.
// - Later burst elements follow sequential or interleaved order from the start column.
module dcs_seq #(
   parameter int FIFO_DEPTH = `DCS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_in,
   // Command pins
   input  wire logic                 cke_in,
   input  wire logic                 cs_n_in,
   input  wire logic                 ras_n_in,
   input  wire logic                 cas_n_in,
   input  wire logic                 we_n_in,
   input  wire logic [`DCS_BW-1:0]   ba_in,
   input  wire logic [`DCS_AW-1:0]   addr_in,
   // Write data pairs captured by the strobe
   input  wire logic                 wr_valid_in,
   input  wire logic [`DCS_DW-1:0]   wr_data_in,
   input  wire logic [`DCS_MW-1:0]   wr_mask_in,
   output logic                      wr_room_out,
   // Array side
   output dcs_pkg::dcs_rd_t          rd_acc_out,
   output logic                      wr_acc_valid_out,
   output dcs_pkg::dcs_wr_t          wr_acc_out,
   input  wire logic                 wr_acc_ready_in,
   output logic                      act_vld_out,
   output logic [`DCS_BW-1:0]        act_bank_out,
   output logic [`DCS_AW-1:0]        act_row_out,
   output logic [`DCS_NBANK-1:0]     bank_open_out,
   output logic [`DCS_NBANK-1:0]     pre_mask_out,
   output logic [2:0]                cas_lat_out,
   output dcs_pkg::dcs_pd_t          pd_state_out
);
   dcs_pkg::dcs_pin_t pin_w, s1_ff, s2_ff, nxt_s1, nxt_s2;
   dcs_pkg::dcs_st_t  st_ff, nxt_st;
   dcs_pkg::dcs_pd_t  pd_ff, nxt_pd;
   dcs_pkg::dcs_rd_t  rd_ff, nxt_rd;
   dcs_pkg::dcs_wr_t  wword;
   logic [2:0]               idx_ff, nxt_idx, left_ff, nxt_left, bl_ff, nxt_bl, cl_ff, nxt_cl, cmd_w;
   logic [`DCS_BW-1:0]       bank_ff, nxt_bank, ba;
   logic [`DCS_CW-1:0]       base_ff, nxt_base, colw;
   logic [`DCS_NBANK-1:0]    open_ff, nxt_open, close_w, pmask_ff;
   logic [`DCS_AW-1:0]       row_ff;
   logic                     ap_ff, nxt_ap, bt_ff, nxt_bt, actv_ff, a10, wpush;
   logic                     is_act, is_rd, is_wr, is_pre, is_bst, is_mrs, rd_ok, wr_ok, ap_fire;
   logic [`DCS_BW-1:0]       abank_ff;
   localparam dcs_pkg::dcs_pin_t PIN_IDLE = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                               default: '0};

   function automatic logic [2:0] pairs_of(input logic [2:0] bl);
      pairs_of = (bl == `DCS_BL_8) ? 3'h4 : (bl == `DCS_BL_4) ? 3'h2 : 3'h1;
   endfunction

   function automatic logic [`DCS_CW-1:0] col_of(input logic [`DCS_CW-1:0] base, input logic [2:0] i,
                                                  input logic [2:0] bl, input logic bt);
      logic [`DCS_CW-1:0] m;
      logic [`DCS_CW-1:0] ie;
      m      = {{(`DCS_CW-3){1'b0}}, (pairs_of(bl) << 1) - 3'h1};
      ie     = {{(`DCS_CW-3){1'b0}}, i};
      col_of = (base & ~m) | ((bt ? (base ^ ie) : (base + ie)) & m);
   endfunction

   // Pins are resynchronised, so every command is seen two cycles late.
   assign pin_w = '{cke: cke_in, cs_n: cs_n_in, ras_n: ras_n_in, cas_n: cas_n_in, we_n: we_n_in,
                    ba: ba_in, addr: addr_in, wvld: wr_valid_in, wdata: wr_data_in, wmask: wr_mask_in};

   always_comb begin
      nxt_s1 = pin_w;
      nxt_s2 = s1_ff;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         // Idle pin levels, so a low clock enable is not seen and no false power-down follows reset.
         s1_ff <= PIN_IDLE;
         s2_ff <= PIN_IDLE;
      end else begin
         s1_ff <= nxt_s1;
         s2_ff <= nxt_s2;
      end
   end

   assign cmd_w   = (s2_ff.cke && !s2_ff.cs_n) ? {s2_ff.ras_n, s2_ff.cas_n, s2_ff.we_n} : `DCS_CMD_NOP;
   assign ba      = s2_ff.ba;
   assign a10     = s2_ff.addr[`DCS_A10];
   assign colw    = s2_ff.addr[`DCS_CW-1:0];
   assign is_act  = cmd_w == `DCS_CMD_ACT;
   assign is_rd   = cmd_w == `DCS_CMD_RD;
   assign is_wr   = cmd_w == `DCS_CMD_WR;
   assign is_pre  = cmd_w == `DCS_CMD_PRE;
   assign is_bst  = cmd_w == `DCS_CMD_BST;
   assign is_mrs  = cmd_w == `DCS_CMD_MRS;
   assign rd_ok   = is_rd && open_ff[ba];
   assign wr_ok   = is_wr && open_ff[ba];
   // A pending self-timed precharge fires in the first idle cycle after its burst.
   assign ap_fire = (st_ff == dcs_pkg::DCS_IDLE) && ap_ff;

   genvar g;
   generate
      for (g = 0; g < `DCS_NBANK; g++) begin : g_bank
         assign close_w[g]  = (is_pre && (a10 || ba == `DCS_BW'(g))) || (ap_fire && bank_ff == `DCS_BW'(g));
         assign nxt_open[g] = (is_act && ba == `DCS_BW'(g)) || (open_ff[g] && !close_w[g]);
      end
   endgenerate

   always_comb begin
      nxt_st   = st_ff;
      nxt_idx  = idx_ff;
      nxt_left = left_ff;
      nxt_bank = bank_ff;
      nxt_base = base_ff;
      nxt_ap   = ap_fire ? 1'b0 : ap_ff;
      nxt_rd   = '0;
      wpush    = 1'b0;
      wword    = '0;
      nxt_bl   = bl_ff;
      nxt_bt   = bt_ff;
      nxt_cl   = cl_ff;
      if (st_ff == dcs_pkg::DCS_READ || (st_ff == dcs_pkg::DCS_WRITE && s2_ff.wvld)) begin
         // Data moves as whole pairs, so an odd tail still spends a full pair.
         nxt_rd.vld  = st_ff == dcs_pkg::DCS_READ;
         nxt_rd.bank = bank_ff;
         nxt_rd.col0 = col_of(base_ff, idx_ff, bl_ff, bt_ff);
         nxt_rd.col1 = col_of(base_ff, idx_ff + 3'h1, bl_ff, bt_ff);
         wpush       = st_ff == dcs_pkg::DCS_WRITE;
         wword       = '{bank: bank_ff, col0: nxt_rd.col0, col1: nxt_rd.col1,
                         data: s2_ff.wdata, mask: s2_ff.wmask};
         if (!nxt_rd.vld) begin
            nxt_rd = '0;
         end
         nxt_idx  = idx_ff + 3'h2;
         nxt_left = left_ff - 3'h1;
         if (left_ff == 3'h1) begin
            nxt_st = dcs_pkg::DCS_IDLE;
         end
      end
      if (rd_ok) begin
         nxt_rd.vld  = 1'b1;
         nxt_rd.bank = ba;
         nxt_rd.col0 = col_of(colw, 3'h0, bl_ff, bt_ff);
         nxt_rd.col1 = col_of(colw, 3'h1, bl_ff, bt_ff);
         nxt_bank    = ba;
         nxt_base    = colw;
         nxt_idx     = 3'h2;
         nxt_left    = pairs_of(bl_ff) - 3'h1;
         nxt_st      = (pairs_of(bl_ff) == 3'h1) ? dcs_pkg::DCS_IDLE : dcs_pkg::DCS_READ;
         nxt_ap      = a10;
      end else if (wr_ok) begin
         nxt_bank = ba;
         nxt_base = colw;
         nxt_idx  = 3'h0;
         nxt_left = pairs_of(bl_ff);
         nxt_st   = dcs_pkg::DCS_WRITE;
         nxt_ap   = a10;
      end else if (is_bst && st_ff == dcs_pkg::DCS_READ) begin
         nxt_st = dcs_pkg::DCS_IDLE;
      end else if (is_pre && st_ff != dcs_pkg::DCS_IDLE && close_w[bank_ff]) begin
         // A precharge of the bursting bank ends the burst; later strobes are ignored.
         nxt_st = dcs_pkg::DCS_IDLE;
      end else if (is_mrs && ba == `DCS_BW'(0)) begin
         if (s2_ff.addr[`DCS_MR_BL_MSB:0] inside {`DCS_BL_2, `DCS_BL_4, `DCS_BL_8}) begin
            nxt_bl = s2_ff.addr[`DCS_MR_BL_MSB:0];
         end
         nxt_bt = s2_ff.addr[`DCS_MR_BT_BIT];
         nxt_cl = s2_ff.addr[`DCS_MR_CL_MSB:`DCS_MR_CL_LSB];
      end
   end

   always_comb begin
      nxt_pd = pd_ff;
      if (s2_ff.cke) begin
         nxt_pd = dcs_pkg::DCS_PD_NONE;
      end else if (pd_ff == dcs_pkg::DCS_PD_NONE && st_ff == dcs_pkg::DCS_IDLE) begin
         nxt_pd = (|open_ff) ? dcs_pkg::DCS_PD_ACT : dcs_pkg::DCS_PD_PRE;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_ff    <= dcs_pkg::DCS_IDLE;
         pd_ff    <= dcs_pkg::DCS_PD_NONE;
         rd_ff    <= '0;
         idx_ff   <= 3'h0;
         left_ff  <= 3'h0;
         bank_ff  <= '0;
         base_ff  <= '0;
         ap_ff    <= 1'b0;
         bl_ff    <= `DCS_MR_BL_RST;
         bt_ff    <= 1'b0;
         cl_ff    <= `DCS_MR_CL_RST;
         open_ff  <= '0;
         pmask_ff <= '0;
         actv_ff  <= 1'b0;
         abank_ff <= '0;
         row_ff   <= '0;
      end else begin
         st_ff    <= nxt_st;
         pd_ff    <= nxt_pd;
         rd_ff    <= nxt_rd;
         idx_ff   <= nxt_idx;
         left_ff  <= nxt_left;
         bank_ff  <= nxt_bank;
         base_ff  <= nxt_base;
         ap_ff    <= nxt_ap;
         bl_ff    <= nxt_bl;
         bt_ff    <= nxt_bt;
         cl_ff    <= nxt_cl;
         open_ff  <= nxt_open;
         pmask_ff <= close_w & open_ff;
         actv_ff  <= is_act;
         abank_ff <= is_act ? ba : abank_ff;
         row_ff   <= is_act ? s2_ff.addr : row_ff;
      end
   end

   // Overflow drops a pair: the controller cannot be stalled, so the array must keep up.
   dcs_fifo #(
      .WIDTH ($bits(dcs_pkg::dcs_wr_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_wbuf (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (wpush),
      .in_data_in    (wword),
      .in_ready_out  (wr_room_out),
      .out_valid_out (wr_acc_valid_out),
      .out_data_out  (wr_acc_out),
      .out_ready_in  (wr_acc_ready_in)
   );

   assign rd_acc_out    = rd_ff;
   assign act_vld_out   = actv_ff;
   assign act_bank_out  = abank_ff;
   assign act_row_out   = row_ff;
   assign bank_open_out = open_ff;
   assign pre_mask_out  = pmask_ff;
   assign cas_lat_out   = cl_ff;
   assign pd_state_out  = pd_ff;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   chk_pre_one_bank: assert property (is_pre && !a10 |=> !open_ff[$past(ba)])
      else $error("single-bank precharge left the bank open");
   chk_pre_all_banks: assert property (is_pre && a10 |=> open_ff == '0)
      else $error("precharge-all left a bank open");
   chk_ap_close: assert property (ap_fire && !is_act |=> !open_ff[$past(bank_ff)])
      else $error("auto precharge did not close its bank");
   chk_ap_off_bit: assert property ((rd_ok || wr_ok) && !a10 |=> !ap_ff)
      else $error("auto precharge armed with A10 low");
   chk_read_restart: assert property (rd_ok |=> rd_ff.vld && rd_ff.col0 == $past(colw) && rd_ff.bank == $past(ba))
      else $error("new read did not restart the burst");
   chk_write_trunc: assert property (wr_ok |=> st_ff == dcs_pkg::DCS_WRITE && idx_ff == 3'h0 && left_ff == pairs_of(bl_ff))
      else $error("new write did not restart the burst");
   chk_bst_stops: assert property (is_bst && st_ff == dcs_pkg::DCS_READ ##1 !rd_ok |=> !rd_ff.vld)
      else $error("read data continued after terminate");
   chk_seq_order: assert property (rd_ok && bl_ff == `DCS_BL_4 && !bt_ff && colw[1:0] == 2'h3
                                   ##1 !(rd_ok || wr_ok || is_bst || is_pre)
                                   |=> rd_ff.vld && rd_ff.col0[1:0] == 2'h1 && rd_ff.col1[1:0] == 2'h2)
      else $error("sequential burst order wrong");
   chk_pd_kind: assert property (!s2_ff.cke && pd_ff == dcs_pkg::DCS_PD_NONE && st_ff == dcs_pkg::DCS_IDLE
                                 |=> pd_ff == ((|$past(open_ff)) ? dcs_pkg::DCS_PD_ACT : dcs_pkg::DCS_PD_PRE))
      else $error("wrong power-down flavour");
   chk_cke_nop: assert property (!s2_ff.cke || s2_ff.cs_n |=> !act_vld_out)
      else $error("command taken without clock enable or select");
endmodule : dcs_seq
`default_nettype wire

// ===== tb/dcs_ctl_model.sv
// Memory controller model that drives command pins and write data pairs into the sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "dcs_params.svh"
module dcs_ctl_model #(
   parameter int ROW_CYC = 6,
   parameter int MRS_CYC = 2,
   parameter int WTR_CYC = 2,
   parameter int DLL_CYC = 200
) (
   // Clock
   input  wire logic          clk_in,
   // Command pins
   output logic               cke_out,
   output logic               cs_n_out,
   output logic [2:0]         cmd_out,
   output logic [`DCS_BW-1:0] ba_out,
   output logic [`DCS_AW-1:0] addr_out,
   // Write data pairs
   output logic               wr_valid_out,
   output logic [`DCS_DW-1:0] wr_data_out,
   output logic [`DCS_MW-1:0] wr_mask_out
);
   initial begin
      cke_out = 1'b1;
      cs_n_out = 1'b1;
      cmd_out = `DCS_CMD_NOP;
      ba_out = 2'h0;
      addr_out = 12'h000;
      wr_valid_out = 1'b0;
      wr_data_out = 32'h0000_0000;
      wr_mask_out = 4'h0;
   end
   // Released address and data lines flip every cycle, so a stale value can never pass for a driven one.
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk_in);
         cs_n_out <= 1'b1;
         cmd_out <= `DCS_CMD_NOP;
         addr_out <= ~addr_out;
         wr_valid_out <= 1'b0;
         wr_data_out <= ~wr_data_out;
      end
   endtask : idle
   task automatic cmd(input logic [2:0] c, input logic [`DCS_BW-1:0] ba, input logic [`DCS_AW-1:0] a, input logic sel);
      @(posedge clk_in);
      cs_n_out <= ~sel;
      cmd_out <= c;
      ba_out <= ba;
      addr_out <= a;
      wr_valid_out <= 1'b0;
      wr_data_out <= ~wr_data_out;
   endtask : cmd
   task automatic act(input logic [`DCS_BW-1:0] ba, input logic [`DCS_AW-1:0] row);
      cmd(`DCS_CMD_ACT, ba, row, 1'b1);
      idle(ROW_CYC);
   endtask : act
   task automatic mrs(input logic [`DCS_BW-1:0] ba, input logic [`DCS_AW-1:0] a);
      cmd(`DCS_CMD_MRS, ba, a, 1'b1);
      idle(MRS_CYC);
   endtask : mrs
   task automatic wr(input logic [1:0] ba, input logic [7:0] col, input logic ap, input int n, input logic [31:0] base);
      logic [`DCS_AW-1:0] a;
      a = 12'h000;
      a[`DCS_CW-1:0] = col;
      a[`DCS_A10] = ap;
      cmd(`DCS_CMD_WR, ba, a, 1'b1);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_in);
         cs_n_out <= 1'b1;
         cmd_out <= `DCS_CMD_NOP;
         addr_out <= ~addr_out;
         wr_valid_out <= 1'b1;
         wr_data_out <= base + 32'(i);
         wr_mask_out <= 4'(i);
      end
   endtask : wr
   // Turnaround after a write counts from the edge after the last full pair.
   task automatic wr_end();
      idle(WTR_CYC + 2);
   endtask : wr_end
   task automatic rd_stop();
      cmd(`DCS_CMD_BST, 2'h0, 12'h000, 1'b1);
   endtask : rd_stop
   task automatic power(input logic on);
      idle(2);
      @(posedge clk_in);
      cke_out <= ~on;
   endtask : power
   task automatic init(input logic [`DCS_AW-1:0] mode);
      cmd(`DCS_CMD_PRE, 2'h0, 12'h400, 1'b1);
      idle(2);
      mrs(2'h1, 12'h000);
      mrs(2'h0, 12'h100);
      idle(DLL_CYC);
      cmd(`DCS_CMD_PRE, 2'h0, 12'h400, 1'b1);
      idle(2);
      repeat (2) begin
         cmd(`DCS_CMD_REF, 2'h0, 12'h000, 1'b1);
         idle(8);
      end
      mrs(2'h0, mode);
   endtask : init
endmodule : dcs_ctl_model
`default_nettype wire

// ===== tb/tb_ddr_command_sequencing.sv
// Self-checking testbench for the command sequencer and its write buffer.
`timescale 1ns/10ps
`default_nettype none
`include "dcs_params.svh"
module tb_ddr_command_sequencing;
   logic                 clk_in;
   logic                 rst_in;
   logic                 cke;
   logic                 cs_n;
   logic [2:0]           cmd;
   logic [1:0]           ba;
   logic [11:0]          addr;
   logic                 wr_valid;
   logic [31:0]          wr_data;
   logic [3:0]           wr_mask;
   logic                 wr_room;
   dcs_pkg::dcs_rd_t     rd_acc;
   logic                 wr_acc_valid;
   dcs_pkg::dcs_wr_t     wr_acc;
   logic                 wr_acc_ready;
   logic                 act_vld;
   logic [1:0]           act_bank;
   logic [11:0]          act_row;
   logic [3:0]           bank_open;
   logic [3:0]           pre_mask;
   logic [2:0]           cas_lat;
   dcs_pkg::dcs_pd_t     pd_state;
   int                   num_errors;
   int                   n_tests;
   int                   act_n;
   logic [3:0]           pre_acc;
   logic [17:0]          rd_q[$];
   logic [17:0]          exp_q[$];
   dcs_pkg::dcs_wr_t     wr_q[$];

   dcs_seq #(.FIFO_DEPTH(8)) dut (.clk_in(clk_in), .rst_in(rst_in), .cke_in(cke), .cs_n_in(cs_n),
      .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]), .ba_in(ba), .addr_in(addr),
      .wr_valid_in(wr_valid), .wr_data_in(wr_data), .wr_mask_in(wr_mask), .wr_room_out(wr_room),
      .rd_acc_out(rd_acc), .wr_acc_valid_out(wr_acc_valid), .wr_acc_out(wr_acc), .wr_acc_ready_in(wr_acc_ready),
      .act_vld_out(act_vld), .act_bank_out(act_bank), .act_row_out(act_row), .bank_open_out(bank_open),
      .pre_mask_out(pre_mask), .cas_lat_out(cas_lat), .pd_state_out(pd_state));
   dcs_ctl_model ctl (.clk_in(clk_in), .cke_out(cke), .cs_n_out(cs_n), .cmd_out(cmd), .ba_out(ba),
      .addr_out(addr), .wr_valid_out(wr_valid), .wr_data_out(wr_data), .wr_mask_out(wr_mask));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (rd_acc.vld === 1'b1) rd_q.push_back({rd_acc.bank, rd_acc.col0, rd_acc.col1});
      if (wr_acc_valid === 1'b1 && wr_acc_ready === 1'b1) wr_q.push_back(wr_acc);
      if (act_vld === 1'b1) act_n++;
      pre_acc = pre_acc | pre_mask;
   end
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_sim();
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   // Columns of pair k of a burst, worked out independently of the design.
   function automatic logic [17:0] rp(logic [1:0] b, logic [7:0] s, int k, int bl, logic bt);
      logic [7:0] m;
      logic [7:0] c0;
      logic [7:0] c1;
      m = 8'(bl - 1);
      c0 = bt ? (s ^ 8'(2 * k)) : ((s & ~m) | ((s + 8'(2 * k)) & m));
      c1 = bt ? (s ^ 8'(2 * k + 1)) : ((s & ~m) | ((s + 8'(2 * k + 1)) & m));
      return {b, c0, c1};
   endfunction : rp
   task automatic clr();
      @(negedge clk_in);
      rd_q.delete();
      exp_q.delete();
      pre_acc = 4'h0;
   endtask : clr
   task automatic rd_cmp();
      ctl.idle(6);
      @(negedge clk_in);
      check("read pair count", rd_q.size(), exp_q.size());
      foreach (exp_q[i]) if (i < rd_q.size()) check("read pair", rd_q[i], exp_q[i]);
   endtask : rd_cmp
   task automatic t_init();
      ctl.init(12'h032);
      ctl.idle(1);
      @(negedge clk_in);
      check("cas latency", cas_lat, 3'h3);
      ctl.cmd(`DCS_CMD_ACT, 2'h0, 12'h000, 1'b0);
      ctl.idle(4);
      @(negedge clk_in);
      check("deselected activation", act_n, 0);
   endtask : t_init
   task automatic t_banks();
      for (int b = 0; b < 4; b++) ctl.act(2'(b), 12'h100 + 12'(b));
      @(negedge clk_in);
      check("activations", act_n, 4);
      check("last row", {act_bank, act_row}, {2'h3, 12'h103});
      check("banks open", bank_open, 4'hF);
      clr();
      ctl.cmd(`DCS_CMD_PRE, 2'h2, 12'h000, 1'b1);
      ctl.idle(4);
      @(negedge clk_in);
      check("single close", {pre_acc, bank_open}, {4'h4, 4'hB});
      ctl.cmd(`DCS_CMD_PRE, 2'h1, 12'h400, 1'b1);
      ctl.idle(4);
      @(negedge clk_in);
      check("close all", {pre_acc & 4'hB, bank_open}, {4'hB, 4'h0});
   endtask : t_banks
   task automatic t_read();
      ctl.act(2'h1, 12'h055);
      for (int bt = 0; bt < 2; bt++) begin
         ctl.mrs(2'h0, 12'h032 | 12'(bt << 3));
         clr();
         ctl.cmd(`DCS_CMD_RD, 2'h1, 12'h003, 1'b1);
         exp_q.push_back(rp(2'h1, 8'h03, 0, 4, bt[0]));
         exp_q.push_back(rp(2'h1, 8'h03, 1, 4, bt[0]));
         rd_cmp();
      end
      clr();
      ctl.cmd(`DCS_CMD_RD, 2'h1, 12'h000, 1'b1);
      ctl.cmd(`DCS_CMD_RD, 2'h1, 12'h008, 1'b1);
      ctl.idle(6);
      ctl.cmd(`DCS_CMD_RD, 2'h3, 12'h000, 1'b1);
      exp_q = '{rp(2'h1, 8'h00, 0, 4, 1'b0), rp(2'h1, 8'h08, 0, 4, 1'b0), rp(2'h1, 8'h08, 1, 4, 1'b0)};
      rd_cmp();
      ctl.mrs(2'h0, 12'h033);
      clr();
      ctl.cmd(`DCS_CMD_RD, 2'h1, 12'h000, 1'b1);
      ctl.rd_stop();
      exp_q = '{rp(2'h1, 8'h00, 0, 8, 1'b0), rp(2'h1, 8'h00, 1, 8, 1'b0)};
      rd_cmp();
   endtask : t_read
   task automatic t_write();
      logic [7:0] s;
      int         j;
      ctl.act(2'h0, 12'h011);
      clr();
      ctl.wr(2'h1, 8'h00, 1'b0, 2, 32'hA000_0000);
      ctl.wr(2'h1, 8'h10, 1'b0, 2, 32'hB000_0000);
      ctl.wr(2'h1, 8'h20, 1'b1, 4, 32'hC000_0000);
      ctl.wr_end();
      ctl.idle(1);
      @(negedge clk_in);
      check("buffer full", wr_room, 1'b0);
      check("auto close", {pre_acc[1], bank_open[1:0]}, {1'b1, 2'h1});
      ctl.wr(2'h0, 8'h00, 1'b0, 1, 32'hD000_0000);
      ctl.wr_end();
      @(posedge clk_in);
      wr_acc_ready <= 1'b1;
      repeat (14) @(posedge clk_in);
      @(negedge clk_in);
      check("written pairs", wr_q.size(), 8);
      for (int k = 0; k < 8 && k < wr_q.size(); k++) begin
         s = (k < 2) ? 8'h00 : (k < 4) ? 8'h10 : 8'h20;
         j = (k < 2) ? k : (k < 4) ? k - 2 : k - 4;
         check("write columns", {wr_q[k].bank, wr_q[k].col0, wr_q[k].col1}, rp(2'h1, s, j, 8, 1'b0));
         check("write data", {wr_q[k].data, wr_q[k].mask}, {({4'hA, 28'h0} + {s[5:4], 28'h0} + 32'(j)), 4'(j)});
      end
      check("buffer empty", wr_acc_valid, 1'b0);
   endtask : t_write
   task automatic t_pd();
      ctl.cmd(`DCS_CMD_PRE, 2'h0, 12'h400, 1'b1);
      ctl.power(1'b1);
      ctl.idle(3);
      @(negedge clk_in);
      check("precharge power-down", pd_state, dcs_pkg::DCS_PD_PRE);
      ctl.power(1'b0);
      ctl.idle(3);
      @(negedge clk_in);
      check("power-down exit", pd_state, dcs_pkg::DCS_PD_NONE);
      ctl.act(2'h2, 12'h000);
      ctl.power(1'b1);
      ctl.idle(3);
      @(negedge clk_in);
      check("active power-down", pd_state, dcs_pkg::DCS_PD_ACT);
      ctl.power(1'b0);
      ctl.idle(3);
   endtask : t_pd
   initial begin
      rst_in = 1'b1;
      wr_acc_ready = 1'b0;
      num_errors = 0;
      n_tests = 0;
      act_n = 0;
      pre_acc = 4'h0;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      check("reset state", {pd_state, bank_open, wr_room, wr_acc_valid, cas_lat}, {3'h1, 4'h0, 1'b1, 1'b0, 3'h2});
      t_init();
      t_banks();
      t_read();
      t_write();
      t_pd();
      end_sim();
   end
   // The planned sequence needs well under 1500 cycles; twice that means a hang.
   initial begin
      repeat (3000) @(posedge clk_in);
      num_errors++;
      end_sim();
   end
endmodule : tb_ddr_command_sequencing
`default_nettype wire
